// ==== core/nonsecure_access_spi_set_pending.sv ====
// access level registers and the non-secure set-spi pending register
module nonsecure_access_spi_set_pending (
    input wire logic clk_in,
    input wire logic nrst_in,
    input nsacr_pkg::bus_req_t bus_req_in,
    output nsacr_pkg::bus_resp_t bus_resp_out,
    input wire logic security_disable_in,
    input wire logic extended_spi_present_in,
    input wire logic [4:0] extended_range_field_in,
    input wire logic message_interrupt_support_in,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] int_secure_in,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] int_level_in,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] other_pending_in,
    input nsacr_pkg::int_event_t activate_in,
    input nsacr_pkg::int_event_t clear_spi_in,
    input nsacr_pkg::int_event_t clear_pending_in,
    input nsacr_pkg::grant_query_t query_in,
    output nsacr_pkg::grant_t grant_out,
    output logic [nsacr_pkg::NUM_IDX-1:0] set_pending_out,
    output nsacr_pkg::redist_upd_t redist_upd_out
);

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    // entries 0 and 1 of ctrl are never written: index 0 is banked per pe
    logic [31:0] ctrl [nsacr_pkg::NUM_CTRL];
    logic [31:0] swi_ctrl [nsacr_pkg::NUM_PE];
    logic [31:0] ctrl_ext [nsacr_pkg::NUM_CTRL];
    logic [6:0] ext_count;

    // ------------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------------
    // extended ids sit above bit 12, so the flat index keeps bit 12 and 9:0
    function automatic logic [10:0] flat_index(input logic [12:0] id);
        return {id[12], id[9:0]}; // RULE_15
    endfunction

    function automatic logic spi_valid(
        input logic [12:0] id,
        input logic espi,
        input logic [6:0] cnt
    );
        logic ok;
        ok = 1'b0;
        if (!id[12]) begin
            ok = id >= nsacr_pkg::SPI_FIRST && id <= nsacr_pkg::SPI_LAST;
        end else if (espi && id[11:10] == 2'h0) begin
            ok = {1'b0, id[9:4]} < cnt;
        end
        return ok;
    endfunction

    // bits of a register that hold a supported field
    function automatic logic [31:0] field_mask(
        input logic ext,
        input logic [5:0] n,
        input logic espi,
        input logic [6:0] cnt
    );
        logic [31:0] m;
        m = '1;
        if (ext) begin
            if (!espi || {1'b0, n} >= cnt) begin
                m = '0; // RULE_14
            end
        end else if (n == nsacr_pkg::PRIV_CTRL_INDEX) begin
            m = '0; // RULE_11
        end else if (n == nsacr_pkg::LAST_CTRL_INDEX) begin
            m = nsacr_pkg::LAST_CTRL_MASK; // RULE_02
        end
        return m;
    endfunction

    function automatic logic [1:0] level_of(
        input logic [12:0] id,
        input logic [2:0] pe
    );
        logic [31:0] word;
        logic [5:0] n;
        logic [3:0] x;
        n = id[9:4]; // RULE_10
        x = id[3:0];
        if (id[12]) begin
            word = ctrl_ext[n];
        end else if (n == nsacr_pkg::SWI_CTRL_INDEX) begin
            word = swi_ctrl[pe];
        end else begin
            word = ctrl[n];
        end
        return word[{x, 1'b0} +: 2]; // RULE_01
    endfunction

    function automatic logic ns_side(input nsacr_pkg::sec_attr_t sec);
        return sec == nsacr_pkg::SEC_NONSECURE || sec == nsacr_pkg::SEC_REALM;
    endfunction

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    logic ctrl_ok;
    logic in_ctrl;
    logic in_ext;
    logic [5:0] reg_n;
    logic [31:0] reg_mask;
    logic ctrl_wr;
    logic ext_wr;
    logic [31:0] wr_word;
    logic [31:0] next_rdata;

    always_comb begin
        ext_count = 7'({2'h0, extended_range_field_in} + 7'h01) << 1; // RULE_14
    end

    always_comb begin
        // the bus master always tags the access with its world
        ctrl_ok = !security_disable_in && !ns_side(bus_req_in.sec); // RULE_13 RULE_23
        in_ctrl = (bus_req_in.addr & ~nsacr_pkg::CTRL_SPAN_MASK) == nsacr_pkg::CTRL_BASE;
        in_ext = (bus_req_in.addr & ~nsacr_pkg::CTRL_SPAN_MASK)
            == nsacr_pkg::CTRL_EXT_BASE; // RULE_15
        reg_n = bus_req_in.addr[7:2]; // RULE_10
        reg_mask = field_mask(in_ext, reg_n, extended_spi_present_in, ext_count);
        // half-word writes are honoured only on the set-spi register
        ctrl_wr = bus_req_in.valid && bus_req_in.write && !bus_req_in.half
            && ctrl_ok && in_ctrl; // RULE_13
        ext_wr = bus_req_in.valid && bus_req_in.write && !bus_req_in.half
            && ctrl_ok && in_ext; // RULE_13
        wr_word = bus_req_in.wdata & reg_mask; // RULE_02
    end

    always_comb begin
        next_rdata = '0;
        if (bus_req_in.valid && !bus_req_in.write && ctrl_ok) begin
            if (in_ext) begin
                next_rdata = ctrl_ext[reg_n] & reg_mask; // RULE_14
            end else if (in_ctrl) begin
                if (reg_n == nsacr_pkg::SWI_CTRL_INDEX) begin
                    next_rdata = swi_ctrl[bus_req_in.pe];
                end else begin
                    next_rdata = ctrl[reg_n] & reg_mask; // RULE_11
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // access level registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < nsacr_pkg::NUM_CTRL; i++) begin
                ctrl[i] <= nsacr_pkg::CTRL_RESET; // RULE_09
            end
        end else if (ctrl_wr && reg_n >= 6'(nsacr_pkg::FIRST_CTRL)) begin
            ctrl[reg_n] <= wr_word; // RULE_02
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < nsacr_pkg::NUM_PE; i++) begin
                swi_ctrl[i] <= nsacr_pkg::CTRL_RESET; // RULE_09
            end
        end else if (ctrl_wr && reg_n == nsacr_pkg::SWI_CTRL_INDEX) begin
            swi_ctrl[bus_req_in.pe] <= wr_word;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < nsacr_pkg::NUM_CTRL; i++) begin
                ctrl_ext[i] <= nsacr_pkg::CTRL_RESET; // RULE_09
            end
        end else if (ext_wr) begin
            ctrl_ext[reg_n] <= wr_word; // RULE_14
        end
    end

    // the redistributor keeps its own copy of the index zero fields
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            redist_upd_out <= '0;
        end else begin
            redist_upd_out.valid <= ctrl_wr && reg_n == nsacr_pkg::SWI_CTRL_INDEX; // RULE_12
            redist_upd_out.pe <= bus_req_in.pe; // RULE_12
            redist_upd_out.data <= wr_word; // RULE_12
        end
    end

    // ------------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------------
    // set-spi is write only and unmapped words read zero
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_resp_out <= '0;
        end else begin
            bus_resp_out.valid <= bus_req_in.valid;
            bus_resp_out.rdata <= next_rdata; // RULE_13
        end
    end

    // ------------------------------------------------------------------------
    // set-spi request
    // ------------------------------------------------------------------------
    logic [12:0] set_id;
    logic [10:0] set_idx;
    logic set_hit;
    logic set_allowed;
    logic set_take;

    always_comb begin
        set_id = bus_req_in.wdata[12:0]; // RULE_16
        set_idx = flat_index(set_id);
        set_hit = bus_req_in.valid && bus_req_in.write
            && bus_req_in.addr == nsacr_pkg::SET_SPI_OFFSET; // RULE_21
        // with security disabled the register serves every spi
        set_allowed = security_disable_in // RULE_17
            || !ns_side(bus_req_in.sec) // RULE_22
            || !int_secure_in[set_idx] // RULE_03
            || level_of(set_id, bus_req_in.pe) != nsacr_pkg::LEVEL_NONE; // RULE_20
        set_take = set_hit && message_interrupt_support_in // RULE_17
            && spi_valid(set_id, extended_spi_present_in, ext_count) // RULE_20
            && !set_pending_out[set_idx] && !other_pending_in[set_idx] // RULE_20
            && set_allowed;
    end

    // ------------------------------------------------------------------------
    // pending state added by set-spi
    // ------------------------------------------------------------------------
    logic [10:0] act_idx;
    logic [10:0] clr_spi_idx;
    logic [10:0] clr_pend_idx;

    always_comb begin
        act_idx = flat_index(activate_in.id);
        clr_spi_idx = flat_index(clear_spi_in.id);
        clr_pend_idx = flat_index(clear_pending_in.id);
    end

    // a set in the same cycle as a clear wins, so no write is lost
    generate
        for (genvar i = 0; i < nsacr_pkg::NUM_IDX; i++) begin : g_pend
            logic hit_clr_spi;
            logic hit_edge_clr;

            always_comb begin
                hit_clr_spi = clear_spi_in.valid && clr_spi_idx == 11'(i);
                hit_edge_clr = !int_level_in[i]
                    && ((activate_in.valid && act_idx == 11'(i))
                    || (clear_pending_in.valid && clr_pend_idx == 11'(i)));
            end

            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    set_pending_out[i] <= 1'b0;
                end else if (set_take && set_idx == 11'(i)) begin
                    set_pending_out[i] <= 1'b1; // RULE_16
                end else if (hit_clr_spi) begin
                    set_pending_out[i] <= 1'b0; // RULE_18 RULE_19
                end else if (hit_edge_clr) begin
                    // level interrupts stay pending through activation
                    set_pending_out[i] <= 1'b0; // RULE_18 RULE_19
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // permission query for the neighbouring register blocks
    // ------------------------------------------------------------------------
    logic [1:0] q_level;
    logic q_restrict;
    logic q_swi_reg;
    nsacr_pkg::grant_t q_grant;

    always_comb begin
        q_level = level_of(query_in.id, query_in.pe);
        // field only matters for a secure interrupt seen from the other world
        q_restrict = !security_disable_in && ns_side(query_in.sec)
            && int_secure_in[flat_index(query_in.id)]; // RULE_03
        q_swi_reg = !query_in.id[12]
            && query_in.id[9:4] == nsacr_pkg::SWI_CTRL_INDEX;
    end

    grant_decode u_grant_decode (
        .level_in(q_level),
        .restrict_in(q_restrict),
        .swi_reg_in(q_swi_reg),
        .ext_in(query_in.id[12]),
        .grant_out(q_grant)
    );

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            grant_out <= '0;
        end else begin
            grant_out <= q_grant; // RULE_04 RULE_05 RULE_06 RULE_08
        end
    end

endmodule // nonsecure_access_spi_set_pending

// ==== core/nsacr_pkg.sv ====
// constants, types and field layouts for the non-secure access control block
// ----------------------------------------------------------------------------
// Notes on behaviour
// RULE_01: sixteen 2-bit fields, field x governs 16n+x
// RULE_02: unsupported interrupts read zero, writes ignored
// RULE_03: level applies only to secure interrupts
// RULE_04: level zero denies all non-secure access
// RULE_05: level one grants set-pending and set-spi
// RULE_06: level two adds clear-pending and active reads
// RULE_07: index zero treats level three as two
// RULE_08: level three adds target and routing access; extended ids get routing only
// RULE_09: reset clears every access level field
// RULE_10: normal register index m/16 at 0xe00
// RULE_11: index one always reads zero
// RULE_12: index zero writes update redistributor copy
// RULE_13: only secure or root may access, security enabled
// RULE_14: extended registers exist only when extended present
// RULE_15: extended index (m-4096)/16 at 0x3600
// RULE_16: set-spi identifier bits 12:0 adds pending
// RULE_17: set-spi reserved without message support
// RULE_18: edge pending cleared by activation or clears
// RULE_19: level pending held until clear-spi write
// RULE_20: invalid, pending or denied set-spi ignored
// RULE_21: set-spi accepts 16-bit and 32-bit writes
// RULE_22: secure set-spi may pend any valid spi
// RULE_23: bus master gives security attribute per access
// ----------------------------------------------------------------------------
package nsacr_pkg;

    // ------------------------------------------------------------------------
    // sizes and offsets
    // ------------------------------------------------------------------------
    localparam int NUM_CTRL = 64;
    localparam int NUM_PE = 8;
    localparam int NUM_IDX = 2048;
    localparam int FIRST_CTRL = 2;
    localparam logic [5:0] SWI_CTRL_INDEX = 6'h00;
    localparam logic [5:0] PRIV_CTRL_INDEX = 6'h01;
    localparam logic [5:0] LAST_CTRL_INDEX = 6'h3f;
    localparam logic [15:0] SET_SPI_OFFSET = 16'h0040;
    localparam logic [15:0] CTRL_BASE = 16'h0e00;
    localparam logic [15:0] CTRL_EXT_BASE = 16'h3600;
    localparam logic [15:0] CTRL_SPAN_MASK = 16'h00ff;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] LAST_CTRL_MASK = 32'h00ff_ffff;
    localparam logic [12:0] SPI_FIRST = 13'h0020;
    localparam logic [12:0] SPI_LAST = 13'h03fb;

    // ------------------------------------------------------------------------
    // access level encodings
    // ------------------------------------------------------------------------
    localparam logic [1:0] LEVEL_NONE = 2'h0;
    localparam logic [1:0] LEVEL_ROUTE = 2'h3;
    // reading clear-pending bits at level one is optional; left off
    localparam logic CLR_READ_AT_PEND = 1'b0;

    typedef enum logic [1:0] {
        SEC_SECURE = 2'h0,
        SEC_NONSECURE = 2'h1,
        SEC_ROOT = 2'h2,
        SEC_REALM = 2'h3
    } sec_attr_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic half;
        sec_attr_t sec;
        logic [2:0] pe;
        logic [15:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
    } bus_resp_t;

    typedef struct packed {
        logic valid;
        logic [12:0] id;
    } int_event_t;

    typedef struct packed {
        logic [12:0] id;
        logic [2:0] pe;
        sec_attr_t sec;
    } grant_query_t;

    typedef struct packed {
        logic set_pend_rw;
        logic set_spi;
        logic swi_gen;
        logic clr_pend_read;
        logic clr_pend_rw;
        logic clr_spi;
        logic active_read;
        logic target_rw;
        logic route_rw;
    } grant_t;

    typedef struct packed {
        logic valid;
        logic [2:0] pe;
        logic [31:0] data;
    } redist_upd_t;

endpackage

// ==== core/grant_decode.sv ====
// decodes one access level into the set of non-secure permissions
module grant_decode (
    input wire logic [1:0] level_in,
    input wire logic restrict_in,
    input wire logic swi_reg_in,
    input wire logic ext_in,
    output nsacr_pkg::grant_t grant_out
);

    always_comb begin
        grant_out = '1;
        if (restrict_in) begin
            grant_out = '0; // RULE_04
            if (level_in != nsacr_pkg::LEVEL_NONE) begin
                grant_out.set_pend_rw = 1'b1; // RULE_05
                grant_out.set_spi = 1'b1; // RULE_05
                grant_out.swi_gen = swi_reg_in; // RULE_05
                grant_out.clr_pend_read = nsacr_pkg::CLR_READ_AT_PEND; // RULE_05
            end
            if (level_in[1]) begin
                grant_out.clr_pend_read = 1'b1; // RULE_06
                grant_out.clr_pend_rw = 1'b1; // RULE_06
                grant_out.clr_spi = 1'b1; // RULE_06
                grant_out.active_read = 1'b1; // RULE_06
            end
            // index zero stops at the level two grants
            if (level_in == nsacr_pkg::LEVEL_ROUTE && !swi_reg_in) begin // RULE_07
                grant_out.target_rw = !ext_in; // RULE_08
                grant_out.route_rw = 1'b1; // RULE_08
            end
        end
    end

endmodule // grant_decode

// ==== tb/nonsecure_access_spi_set_pending_properties.sv ====
// concurrent checks on the ports of the access control and set-spi block
module spi_pend_checker (
    input wire logic clk_in,
    input wire logic nrst_in,
    input nsacr_pkg::bus_req_t bus_req_in,
    input nsacr_pkg::bus_resp_t bus_resp_out,
    input wire logic security_disable_in,
    input wire logic extended_spi_present_in,
    input wire logic [4:0] extended_range_field_in,
    input wire logic message_interrupt_support_in,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] int_secure_in,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] int_level_in,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] other_pending_in,
    input nsacr_pkg::int_event_t activate_in,
    input nsacr_pkg::int_event_t clear_spi_in,
    input nsacr_pkg::int_event_t clear_pending_in,
    input nsacr_pkg::grant_query_t query_in,
    input nsacr_pkg::grant_t grant_out,
    input wire logic [nsacr_pkg::NUM_IDX-1:0] set_pending_out,
    input nsacr_pkg::redist_upd_t redist_upd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    logic rd;
    logic setw;
    assign rd = bus_req_in.valid && !bus_req_in.write;
    assign setw = bus_req_in.valid && bus_req_in.write
        && bus_req_in.addr == nsacr_pkg::SET_SPI_OFFSET;
    // --------
    // bus answers
    // --------
    a_resp_timing: assert property (bus_resp_out.valid == $past(bus_req_in.valid))
        else $error("response not one cycle after request");
    a_write_zero: assert property (bus_req_in.valid && bus_req_in.write |=>
        bus_resp_out.rdata == 32'h0) else $error("write returned data");
    a_ns_raz: assert property (rd && (bus_req_in.sec == nsacr_pkg::SEC_NONSECURE
        || bus_req_in.sec == nsacr_pkg::SEC_REALM) |=> bus_resp_out.rdata == 32'h0)
        else $error("nonsecure read not zero");
    a_ds_raz: assert property (rd && security_disable_in |=> bus_resp_out.rdata == 32'h0)
        else $error("read with security disabled not zero");
    a_idx1_raz: assert property (rd && bus_req_in.addr == 16'h0e04 |=>
        bus_resp_out.rdata == 32'h0) else $error("index one not zero");
    a_ext_res0: assert property (rd && !extended_spi_present_in
        && bus_req_in.addr[15:8] == 8'h36 |=> bus_resp_out.rdata == 32'h0)
        else $error("absent extended register not zero");
    a_redist_copy: assert property (bus_req_in.valid && bus_req_in.write && !bus_req_in.half
        && bus_req_in.addr == 16'h0e00 && bus_req_in.sec == nsacr_pkg::SEC_SECURE
        && !security_disable_in |=> redist_upd_out.valid && redist_upd_out.pe ==
        $past(bus_req_in.pe) && redist_upd_out.data == $past(bus_req_in.wdata))
        else $error("redistributor copy not updated");
    // --------
    // pending and grants
    // --------
    a_set_cause: assert property ((set_pending_out & ~$past(set_pending_out)) != '0 |->
        $past(setw && message_interrupt_support_in)) else $error("pending set without cause");
    a_level_hold: assert property ((($past(set_pending_out) & ~set_pending_out
        & $past(int_level_in)) != '0) |-> $past(clear_spi_in.valid))
        else $error("level pending dropped without clear");
    a_secure_grant: assert property (query_in.sec == nsacr_pkg::SEC_SECURE |=>
        grant_out == 9'h1ff) else $error("secure query restricted");
    c_redist: cover property ($rose(redist_upd_out.valid));
    c_pend: cover property ((set_pending_out & ~$past(set_pending_out)) != '0);
    c_grant: cover property (query_in.sec == nsacr_pkg::SEC_NONSECURE ##1 grant_out != '0);
endmodule // spi_pend_checker

bind nonsecure_access_spi_set_pending spi_pend_checker i_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .bus_req_in(bus_req_in), .bus_resp_out(bus_resp_out),
    .security_disable_in(security_disable_in), .extended_spi_present_in(extended_spi_present_in),
    .extended_range_field_in(extended_range_field_in),
    .message_interrupt_support_in(message_interrupt_support_in), .int_secure_in(int_secure_in),
    .int_level_in(int_level_in), .other_pending_in(other_pending_in), .activate_in(activate_in),
    .clear_spi_in(clear_spi_in), .clear_pending_in(clear_pending_in), .query_in(query_in),
    .grant_out(grant_out), .set_pending_out(set_pending_out), .redist_upd_out(redist_upd_out)
);

// ==== tb/tb_nonsecure_access_spi_set_pending.sv ====
// self-checking bench for the access control and set-spi block
module tb_nonsecure_access_spi_set_pending;
    timeunit 1ns;
    timeprecision 1ps;
    localparam nsacr_pkg::sec_attr_t S = nsacr_pkg::SEC_SECURE;
    localparam nsacr_pkg::sec_attr_t N = nsacr_pkg::SEC_NONSECURE;
    logic clk_in, nrst_in, ds, esp, msg;
    logic [4:0] erange;
    logic [nsacr_pkg::NUM_IDX-1:0] sec_v, lvl_v, oth_v, pend, exp_pend;
    nsacr_pkg::bus_req_t req;
    nsacr_pkg::bus_resp_t resp;
    nsacr_pkg::int_event_t act, clrs, clrp;
    nsacr_pkg::grant_query_t qry;
    nsacr_pkg::grant_t grant;
    nsacr_pkg::redist_upd_t redist;
    logic [31:0] exp_q[$];
    logic [31:0] w, e;
    logic [15:0] rnd, a;
    logic [8:0] lvl_grant[4] = '{9'h000, 9'h180, 9'h19c, 9'h19f};
    int err_total, cmp_count;

    nonsecure_access_spi_set_pending i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .bus_req_in(req), .bus_resp_out(resp),
        .security_disable_in(ds), .extended_spi_present_in(esp),
        .extended_range_field_in(erange), .message_interrupt_support_in(msg),
        .int_secure_in(sec_v), .int_level_in(lvl_v), .other_pending_in(oth_v),
        .activate_in(act), .clear_spi_in(clrs), .clear_pending_in(clrp), .query_in(qry),
        .grant_out(grant), .set_pending_out(pend), .redist_upd_out(redist)
    );

    // --------
    // helpers
    // --------
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic note(input logic bad, input string what);
        cmp_count++;
        if (bad) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic final_report();
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one request per call; back-to-back calls keep the strobe up
    task automatic acc(input logic wr, input logic hf, input nsacr_pkg::sec_attr_t s,
        input logic [2:0] p, input logic [15:0] ad, input logic [31:0] d, input logic [31:0] x);
        @(posedge clk_in);
        req <= '{1'b1, wr, hf, s, p, ad, d};
        exp_q.push_back(x);
    endtask
    task automatic idle();
        @(posedge clk_in);
        req.valid <= 1'b0;
    endtask
    task automatic spi(input nsacr_pkg::sec_attr_t s, input logic hf, input logic [12:0] id,
        input logic x);
        acc(1'b1, hf, s, 3'h0, nsacr_pkg::SET_SPI_OFFSET, {19'h0, id}, 32'h0);
        idle();
        @(negedge clk_in);
        if (x) exp_pend[id[9:0]] = 1'b1;
        note(pend !== exp_pend, "set-spi pending");
        @(posedge clk_in);
    endtask
    task automatic ask(input logic [12:0] id, input nsacr_pkg::sec_attr_t s,
        input logic [2:0] p, input logic [8:0] x, input logic [8:0] m);
        @(posedge clk_in);
        qry <= '{id, p, s};
        repeat (2) @(negedge clk_in);
        note(((9'(grant) ^ x) & m) !== 9'h0, "grant");
        @(posedge clk_in);
    endtask
    task automatic pulse(input int k, input logic [12:0] id);
        @(posedge clk_in);
        act <= '{k == 0, id};
        clrs <= '{k == 1, id};
        clrp <= '{k == 2, id};
        @(posedge clk_in);
        act.valid <= 1'b0;
        clrs.valid <= 1'b0;
        clrp.valid <= 1'b0;
        @(negedge clk_in);
        note(pend !== exp_pend, "pending after event");
    endtask
    // responses are matched in order against the notes left by acc
    always @(negedge clk_in) begin
        if (resp.valid === 1'b1) begin
            if (exp_q.size() == 0) note(1'b1, "response without request");
            else note(resp.rdata !== exp_q.pop_front(), "read data");
        end
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        note(1'b1, "timeout");
        final_report();
    end

    // --------
    // scenarios
    // --------
    initial begin
        {nrst_in, ds, esp, msg, erange, sec_v, lvl_v, oth_v} = '0;
        {req, act, clrs, clrp, qry, exp_pend} = '0;
        msg = 1'b1;
        sec_v = '1;
        lvl_v[32] = 1'b1;
        rnd = 16'he6a3;
        err_total = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        note(pend !== '0 || redist.valid !== 1'b0, "outputs after reset");
        for (int n = 0; n < 64; n++) acc(0, 0, S, 0, 16'h0e00 + 16'(4 * n), 0, 0);
        idle();
        $display("test reset values done");
        for (int n = 0; n < 64; n++) begin
            rnd = lfsr(rnd);
            w = {rnd, ~rnd} & (n == 0 ? 32'haaaa_aaaa : 32'hffff_ffff);
            a = nsacr_pkg::CTRL_BASE + 16'(4 * n);
            e = n == 1 ? 32'h0 : (n == 63 ? w & nsacr_pkg::LAST_CTRL_MASK : w);
            acc(1, 0, S, 0, a, w, 0);
            acc(0, 0, S, 0, a, 0, e);
        end
        acc(1, 0, S, 0, 16'h0e08, 32'h0000_00e4, 0);
        acc(1, 0, N, 0, 16'h0e08, 32'h0, 0);
        acc(1, 0, nsacr_pkg::SEC_REALM, 0, 16'h0e08, 32'h0, 0);
        acc(1, 1, S, 0, 16'h0e08, 32'h0, 0);
        acc(0, 0, N, 0, 16'h0e08, 0, 0);
        acc(0, 0, nsacr_pkg::SEC_ROOT, 0, 16'h0e08, 0, 32'h0000_00e4);
        acc(1, 0, S, 3'h2, 16'h0e00, 32'h0000_0c00, 0);
        idle();
        @(negedge clk_in);
        note(redist !== {1'b1, 3'h2, 32'h0000_0c00}, "redistributor update");
        acc(0, 0, S, 3'h2, 16'h0e00, 0, 32'h0000_0c00);
        acc(0, 0, S, 3'h3, 16'h0e00, 0, 32'h0);
        idle();
        ds <= 1'b1;
        acc(1, 0, S, 0, 16'h0e08, 32'h0, 0);
        acc(0, 0, S, 0, 16'h0e08, 0, 0);
        idle();
        ds <= 1'b0;
        acc(0, 0, S, 0, 16'h0e08, 0, 32'h0000_00e4);
        acc(0, 0, S, 0, 16'h3600, 0, 0);
        idle();
        esp <= 1'b1;
        for (int n = 0; n < 3; n++) acc(1, 0, S, 0, 16'h3600 + 16'(4 * n), 32'h3, 0);
        for (int n = 0; n < 3; n++) acc(0, 0, S, 0, 16'h3600 + 16'(4 * n), 0, n < 2 ? 3 : 0);
        idle();
        $display("test register access done");
        for (int x = 0; x < 4; x++) ask(13'(32 + x), N, 0, lvl_grant[x], 9'h19f);
        ask(13'd4096, N, 0, 9'h19d, 9'h19f);
        ask(13'd5, N, 3'h2, 9'h044, 9'h047);
        ask(13'd32, S, 0, 9'h1ff, 9'h1ff);
        sec_v[32] <= 1'b0;
        ask(13'd32, N, 0, 9'h1ff, 9'h1ff);
        sec_v[32] <= 1'b1;
        $display("test grants done");
        spi(N, 0, 13'd32, 0);
        spi(N, 0, 13'd33, 1);
        spi(N, 1, 13'd34, 1);
        spi(N, 0, 13'd33, 0);
        spi(S, 0, 13'd32, 1);
        spi(S, 0, 13'd1020, 0);
        oth_v[36] <= 1'b1;
        spi(S, 0, 13'd36, 0);
        msg <= 1'b0;
        spi(S, 0, 13'd35, 0);
        msg <= 1'b1;
        ds <= 1'b1;
        spi(N, 0, 13'd37, 1);
        ds <= 1'b0;
        exp_pend[33] = 1'b0;
        pulse(0, 13'd33);
        pulse(0, 13'd32);
        exp_pend[32] = 1'b0;
        pulse(1, 13'd32);
        exp_pend[34] = 1'b0;
        pulse(2, 13'd34);
        $display("test set-spi done");
        repeat (2) @(negedge clk_in);
        note(exp_q.size() != 0, "responses missing");
        final_report();
    end
endmodule // tb_nonsecure_access_spi_set_pending
